// *** core/isp_regs.vh ***
// constants shared by the two-wire slave command port and its receive fifo
// assumes: included by bare name from every design file of the port
`ifndef ISP_REGS_VH
`define ISP_REGS_VH

// ****************************************************************
// bus framing
// ****************************************************************
`define ISP_BYTE_BITS      4'h8
`define ISP_BIT_ZERO       4'h0
`define ISP_ADDR_W         7
// arbitrary neutral slave address, replace per product
`define ISP_SLAVE_ADDR     7'h2A
`define ISP_DIR_READ       1'b1
`define ISP_IDLE_BYTE      8'hFF

// ****************************************************************
// protocol engine states
// ****************************************************************
`define ISP_ST_IDLE        3'h0
`define ISP_ST_ADDR        3'h1
`define ISP_ST_ADDR_ACK    3'h2
`define ISP_ST_WR          3'h3
`define ISP_ST_WR_ACK      3'h4
`define ISP_ST_RD          3'h5
`define ISP_ST_RD_ACK      3'h6
`define ISP_ST_IGNORE      3'h7

// ****************************************************************
// receive fifo
// ****************************************************************
`define ISP_FIFO_DEPTH     4
`define ISP_FIFO_AW        2
`define ISP_RX_W           9

`endif

// *** core/isp_fifo.v ***
// small flop-based fifo between the bit engine and the user side
// assumes: one clock, writer honours o_wr_ready, reader honours o_rd_valid
`include "isp_regs.vh"
`default_nettype none

module isp_fifo #(
    parameter WIDTH = `ISP_RX_W,
    parameter DEPTH = `ISP_FIFO_DEPTH,
    parameter AW    = `ISP_FIFO_AW
) (
    input  wire             i_clk_sys,
    input  wire             i_rstn,
    input  wire             i_wr_valid,
    input  wire [WIDTH-1:0] i_wr_data,
    output wire             o_wr_ready,
    output wire             o_rd_valid,
    output wire [WIDTH-1:0] o_rd_data,
    input  wire             i_rd_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // honest flags straight from the occupancy count
    assign o_wr_ready = (count != DEPTH[AW:0]);
    assign o_rd_valid = (count != {(AW+1){1'b0}});
    assign o_rd_data  = mem[rd_ptr];
    assign push       = i_wr_valid & o_wr_ready;
    assign pop        = o_rd_valid & i_rd_ready;

    // storage, not reset: only valid slots are ever read
    always @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

    // pointers wrap at DEPTH, which need not be a power of two
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule
`default_nettype wire

// *** core/isp_slave.v ***
// two-wire bus slave command port: address match, write stream, read stream
// assumes: scl and sda arrive asynchronously from pins and are oversampled
// by i_clk_sys (100 MHz); the sda pad pulls low while o_sda_oe is high;
// scl is never stretched, the master owns all bus timing
`include "isp_regs.vh"
`default_nettype none

// Behaviour
// (RULE1) works at 100 and 400 kbit/s by oversampling both lines at 100 MHz
// (RULE2) sda falling while scl high is start; address reception begins
// (RULE3) sda rising while scl high is stop; port returns to idle
// (RULE4) repeated start without stop restarts address reception at once
// (RULE5) eight bits msb first per byte, then one acknowledge slot
// (RULE6) sda changes only while scl low, except start and stop
// (RULE7) incoming sda bits are captured on rising scl
// (RULE8) transmitted bits are driven at the falling scl before their pulse
// (RULE9) master makes every scl pulse and releases sda before read bits
// (RULE10) last address bit: 0 master writes, 1 device sends
// (RULE11) acknowledge holds sda low across the whole ack pulse
// (RULE12) master acknowledges read bytes to keep the device sending
// (RULE13) busy or asleep: the address byte is left unacknowledged
// (RULE14) rejected bytes after the address are left unacknowledged
// (RULE15) after any nack the master restarts with start or stop-start
// (RULE16) master nack ends a read; device releases sda for stop
// (RULE17) first byte after a write address is the command byte
// (RULE18) read data comes from the user side, which tracks the address
// (RULE19) master starts only on an idle bus and sets byte count
// (RULE20) master waits out oscillator warm-up after power-on
// (RULE21) only a matching seven-bit address is served; else ignore till start
module isp_slave #(
    parameter [`ISP_ADDR_W-1:0] SLAVE_ADDR = `ISP_SLAVE_ADDR,
    parameter                   FIFO_DEPTH = `ISP_FIFO_DEPTH
) (
    input  wire       i_clk_sys,
    input  wire       i_rstn,
    input  wire       i_scl,
    input  wire       i_sda,
    output reg        o_sda_oe,
    output reg        o_sda_out,
    input  wire       i_busy,
    input  wire       i_accept,
    output reg        o_rx_valid,
    output reg  [7:0] o_rx_data,
    output reg        o_rx_cmd,
    input  wire       i_rx_ready,
    input  wire       i_tx_valid,
    input  wire [7:0] i_tx_data,
    output reg        o_tx_req,
    output reg        o_rd_start,
    output reg        o_active
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // open drain: a zero bit pulls the line, a one bit releases it
    function drive_for;
        input bit_value;
        begin
            drive_for = ~bit_value;
        end
    endfunction

    // byte to send, falling back to all ones when the user has none
    function [7:0] tx_pick;
        input       valid;
        input [7:0] data;
        begin
            tx_pick = valid ? data : `ISP_IDLE_BYTE;
        end
    endfunction

    // next byte to shift out; its msb goes on the line at the slot's fall
    wire [7:0] tx_next = tx_pick(i_tx_valid, i_tx_data);

    // ****************************************************************
    // pin synchronisers and condition detection
    // ****************************************************************

    reg scl_meta;
    reg scl_sync;
    reg scl_prev;
    reg sda_meta;
    reg sda_sync;
    reg sda_prev;

    // two flops per pin before any logic looks at it [RULE1]
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= i_scl;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= i_sda;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    wire scl_rise = scl_sync & ~scl_prev;
    wire scl_fall = ~scl_sync & scl_prev;
    // conditions only count while scl stays high on both samples [RULE6]
    wire bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;   // [RULE2] [RULE4]
    wire bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;   // [RULE3]

    // ****************************************************************
    // receive fifo in the write data path
    // ****************************************************************

    reg                  fifo_push;
    reg  [`ISP_RX_W-1:0] fifo_wdata;
    wire                 fifo_ready;
    wire                 fifo_valid;
    wire [`ISP_RX_W-1:0] fifo_rdata;
    wire                 fifo_pop;

    // output stage takes a word whenever it is empty or being drained
    assign fifo_pop = fifo_valid & (~o_rx_valid | i_rx_ready);

    isp_fifo #(
        .WIDTH (`ISP_RX_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (`ISP_FIFO_AW)
    ) u_rx_fifo (
        .i_clk_sys  (i_clk_sys),
        .i_rstn     (i_rstn),
        .i_wr_valid (fifo_push),
        .i_wr_data  (fifo_wdata),
        .o_wr_ready (fifo_ready),
        .o_rd_valid (fifo_valid),
        .o_rd_data  (fifo_rdata),
        .i_rd_ready (fifo_pop)
    );

    // registered user-side stream so outputs come from flops
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
            o_rx_cmd   <= 1'b0;
        end else if (fifo_pop) begin
            o_rx_valid <= 1'b1;
            o_rx_cmd   <= fifo_rdata[8];
            o_rx_data  <= fifo_rdata[7:0];
        end else if (i_rx_ready) begin
            o_rx_valid <= 1'b0;
        end
    end

    // ****************************************************************
    // protocol engine
    // ****************************************************************

    reg [2:0] state;
    reg [3:0] bits;      // rising edges seen in the current byte
    reg [7:0] rx_sh;
    reg [7:0] tx_sh;
    reg       dir_read;
    reg       first_wr;  // next written byte is the command byte
    reg       master_ack;

    // state and shifting; start and stop win over every bit event
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state      <= `ISP_ST_IDLE;
            bits       <= `ISP_BIT_ZERO;
            rx_sh      <= 8'h00;
            tx_sh      <= 8'h00;
            dir_read   <= 1'b0;
            first_wr   <= 1'b0;
            master_ack <= 1'b0;
            o_sda_oe   <= 1'b0;
            o_sda_out  <= 1'b0;
            o_tx_req   <= 1'b0;
            o_rd_start <= 1'b0;
            o_active   <= 1'b0;
            fifo_push  <= 1'b0;
            fifo_wdata <= {`ISP_RX_W{1'b0}};
        end else begin
            o_tx_req   <= 1'b0;
            o_rd_start <= 1'b0;
            fifo_push  <= 1'b0;
            o_sda_out  <= 1'b0;
            if (bus_start) begin
                // new transfer, even in the middle of an old one [RULE2] [RULE4]
                state    <= `ISP_ST_ADDR;
                bits     <= `ISP_BIT_ZERO;
                o_sda_oe <= 1'b0;
                o_active <= 1'b0;
            end else if (bus_stop) begin
                state    <= `ISP_ST_IDLE;                        // [RULE3]
                o_sda_oe <= 1'b0;
                o_active <= 1'b0;
            end else begin
                case (state)
                    `ISP_ST_ADDR: begin
                        if (scl_rise) begin
                            rx_sh <= {rx_sh[6:0], sda_sync};      // [RULE7] [RULE5]
                            bits  <= bits + 1'b1;
                        end else if (scl_fall && bits == `ISP_BYTE_BITS) begin
                            bits     <= `ISP_BIT_ZERO;
                            dir_read <= (rx_sh[0] == `ISP_DIR_READ); // [RULE10]
                            // match and not busy: pull sda for the ack slot
                            if (rx_sh[7:1] == SLAVE_ADDR && !i_busy) begin // [RULE21]
                                o_sda_oe <= 1'b1;                        // [RULE11]
                                o_active <= 1'b1;
                                state    <= `ISP_ST_ADDR_ACK;
                                if (rx_sh[0] == `ISP_DIR_READ) begin
                                    o_rd_start <= 1'b1;                  // [RULE18]
                                    o_tx_req   <= 1'b1;
                                end
                            end else begin
                                o_sda_oe <= 1'b0;                        // [RULE13]
                                state    <= `ISP_ST_IGNORE;              // [RULE21]
                            end
                        end
                    end
                    `ISP_ST_ADDR_ACK: begin
                        // ack held low until scl falls again [RULE11]
                        if (scl_fall) begin
                            if (dir_read) begin
                                tx_sh    <= tx_next;
                                o_sda_oe <= drive_for(tx_next[7]);      // [RULE8]
                                state    <= `ISP_ST_RD;
                            end else begin
                                o_sda_oe <= 1'b0;
                                first_wr <= 1'b1;
                                state    <= `ISP_ST_WR;
                            end
                        end
                    end
                    `ISP_ST_WR: begin
                        if (scl_rise) begin
                            rx_sh <= {rx_sh[6:0], sda_sync};      // [RULE7] [RULE5]
                            bits  <= bits + 1'b1;
                        end else if (scl_fall && bits == `ISP_BYTE_BITS) begin
                            bits <= `ISP_BIT_ZERO;
                            // refuse when the user rejects or the fifo is full
                            if (i_accept && fifo_ready) begin
                                fifo_push  <= 1'b1;
                                fifo_wdata <= {first_wr, rx_sh};  // [RULE17]
                                first_wr   <= 1'b0;
                                o_sda_oe   <= 1'b1;               // [RULE11]
                                state      <= `ISP_ST_WR_ACK;
                            end else begin
                                o_sda_oe <= 1'b0;                 // [RULE14]
                                o_active <= 1'b0;
                                state    <= `ISP_ST_IGNORE;
                            end
                        end
                    end
                    `ISP_ST_WR_ACK: begin
                        if (scl_fall) begin
                            o_sda_oe <= 1'b0;
                            state    <= `ISP_ST_WR;
                        end
                    end
                    `ISP_ST_RD: begin
                        if (scl_rise) begin
                            bits <= bits + 1'b1;
                        end else if (scl_fall) begin
                            if (bits == `ISP_BYTE_BITS) begin
                                // let the master drive its ack bit
                                bits     <= `ISP_BIT_ZERO;
                                o_sda_oe <= 1'b0;
                                state    <= `ISP_ST_RD_ACK;
                            end else begin
                                tx_sh    <= {tx_sh[6:0], 1'b0};
                                o_sda_oe <= drive_for(tx_sh[6]);  // [RULE8] [RULE5]
                            end
                        end
                    end
                    `ISP_ST_RD_ACK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_sync;              // [RULE12]
                            o_tx_req   <= ~sda_sync;
                        end else if (scl_fall) begin
                            if (master_ack) begin
                                tx_sh    <= tx_next;
                                o_sda_oe <= drive_for(tx_next[7]);
                                state    <= `ISP_ST_RD;
                            end else begin
                                o_sda_oe <= 1'b0;                 // [RULE16]
                                o_active <= 1'b0;
                                state    <= `ISP_ST_IGNORE;
                            end
                        end
                    end
                    `ISP_ST_IGNORE: begin
                        // bus belongs to someone else until the next start
                        o_sda_oe <= 1'b0;
                    end
                    `ISP_ST_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    default: begin
                        state    <= `ISP_ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// *** testbench/isp_slave_checker.sv ***
// concurrent checks on the slave port pins and user streams
// assumes: bound to isp_slave, one clock domain, reset async active low
`default_nettype none

module isp_slave_checker (
    input wire logic       i_clk_sys,
    input wire logic       i_rstn,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda_oe,
    input wire logic       o_sda_out,
    input wire logic       i_busy,
    input wire logic       o_rx_valid,
    input wire logic [7:0] o_rx_data,
    input wire logic       o_rx_cmd,
    input wire logic       i_rx_ready,
    input wire logic       o_tx_req,
    input wire logic       o_rd_start,
    input wire logic       o_active
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] lowcnt;
    logic       scl_q;
    logic       sda_q;
    logic       sda_qq;

    // pin samples and scl-low age; lines idle high so reset to one
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lowcnt <= 4'h0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            sda_qq <= 1'b1;
        end else begin
            lowcnt <= i_scl ? 4'h0 : ((lowcnt == 4'hF) ? 4'hF : lowcnt + 4'h1);
            scl_q  <= i_scl;
            sda_q  <= i_sda;
            sda_qq <= sda_q;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    sequence s_ack_drive;
        ##[0:3] o_sda_oe;
    endsequence
    sequence s_stop_seen;
        scl_q && sda_q && !sda_qq;
    endsequence

    AST_DRV_ZERO: assert property (o_sda_oe |-> !o_sda_out)
        else $error("sda driven high");
    AST_OE_SCL_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda driver changed while scl high");
    AST_OE_AFTER_FALL: assert property ($changed(o_sda_oe) |-> lowcnt inside {[2:5]})
        else $error("sda driver not moved just after scl fall");
    AST_ACK_HOLD: assert property (o_sda_oe && i_scl |=> o_sda_oe || !i_scl)
        else $error("low level dropped in high phase");
    AST_STOP_IDLE: assert property (s_stop_seen |-> ##[0:5] !o_active)
        else $error("still active after stop");
    AST_RD_START: assert property (o_rd_start |-> s_ack_drive ##1 !o_rd_start)
        else $error("read start without ack drive");
    AST_TXREQ_PULSE: assert property (o_tx_req |=> !o_tx_req)
        else $error("byte request longer than one cycle");
    AST_BUSY_NACK: assert property ($rose(o_active) |-> !$past(i_busy))
        else $error("addressed while busy");
    AST_RX_HOLD: assert property (o_rx_valid && !i_rx_ready |=>
        o_rx_valid && $stable(o_rx_data) && $stable(o_rx_cmd))
        else $error("received word dropped before taken");
endmodule

bind isp_slave isp_slave_checker i_chk (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda_oe  (o_sda_oe),
    .o_sda_out (o_sda_out),
    .i_busy    (i_busy),
    .o_rx_valid(o_rx_valid),
    .o_rx_data (o_rx_data),
    .o_rx_cmd  (o_rx_cmd),
    .i_rx_ready(i_rx_ready),
    .o_tx_req  (o_tx_req),
    .o_rd_start(o_rd_start),
    .o_active  (o_active)
);

`default_nettype wire

// *** testbench/isp_master_model.sv ***
// behavioural bus master: start, stop, byte write and byte read
// assumes: sda input is the resolved wired-and line with pull-up
`default_nettype none

module isp_master_model (
    output logic      o_scl,
    output logic      o_sda_low,
    input wire logic  i_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    int unsigned t_q = 20; // quarter of the 80 ns link clock; raise for slow rates

    // bus idle: both lines high
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // data moves only while scl low, one pulse per bit
    task automatic put_bit(input logic b);
        #t_q o_sda_low = !b;
        #t_q o_scl = 1'b1;
        #(2 * t_q) o_scl = 1'b0;
    endtask

    // released before the read clock, sampled mid high phase
    task automatic get_bit(output logic b);
        #t_q o_sda_low = 1'b0;
        #t_q o_scl = 1'b1;
        #t_q b = i_sda;
        #t_q o_scl = 1'b0;
    endtask

    // odd offset keeps scl edges away from the system clock edge;
    // the leading gap lets a slave drop its ack before scl rises
    task automatic start_cond;
        #(t_q + 3) o_sda_low = 1'b0;
        #t_q o_scl = 1'b1;
        #t_q o_sda_low = 1'b1;
        #t_q o_scl = 1'b0;
    endtask

    task automatic stop_cond;
        #t_q o_sda_low = 1'b1;
        #t_q o_scl = 1'b1;
        #t_q o_sda_low = 1'b0;
        #t_q;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask

    // last byte left unacknowledged to end the read
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule

`default_nettype wire

// *** testbench/tb_isp_slave.sv ***
// self-checking bench of the slave port against a bus master model
// assumes: design files under core, header found by bare name
`include "isp_regs.vh"
`default_nettype none

module tb_isp_slave;
    timeunit 1ns;
    timeprecision 100ps;

    logic       i_clk_sys = 1'b0;
    logic       i_rstn    = 1'b0;
    logic       busy      = 1'b0;
    logic       accept    = 1'b1;
    logic       rx_ready  = 1'b0;
    logic       tx_valid  = 1'b0;
    logic [7:0] tx_data   = 8'h00;
    logic       stall     = 1'b0;
    logic       rd_seen   = 1'b0;
    wire logic  scl;
    wire logic  sda_low;
    wire logic  sda_line;
    logic       sda_oe;
    logic       sda_out;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_cmd;
    logic       tx_req;
    logic       rd_start;
    logic       active;
    logic [8:0] exp_rx[$];
    logic [8:0] got_rx[$];
    logic [7:0] exp_tx[$];
    int         err_count = 0;
    int         cmp_count = 0;
    localparam logic [7:0] ADDR_W = {`ISP_SLAVE_ADDR, 1'b0};

    always #5 i_clk_sys = ~i_clk_sys;
    // wired-and with pull-up: released line reads high
    assign sda_line = ~(sda_low | sda_oe);

    isp_slave i_dut (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_scl     (scl),
        .i_sda     (sda_line),
        .o_sda_oe  (sda_oe),
        .o_sda_out (sda_out),
        .i_busy    (busy),
        .i_accept  (accept),
        .o_rx_valid(rx_valid),
        .o_rx_data (rx_data),
        .o_rx_cmd  (rx_cmd),
        .i_rx_ready(rx_ready),
        .i_tx_valid(tx_valid),
        .i_tx_data (tx_data),
        .o_tx_req  (tx_req),
        .o_rd_start(rd_start),
        .o_active  (active)
    );

    isp_master_model i_mst (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda_line));

    // consumer with random stalls; received words collected in order
    always @(posedge i_clk_sys) begin
        if ((rx_valid && rx_ready) === 1'b1) got_rx.push_back({rx_cmd, rx_data});
        if (rd_start === 1'b1) rd_seen = 1'b1;
        #1 rx_ready = !stall && ($urandom % 3 != 0);
    end

    // read byte source answers each request with a fresh random byte
    always @(posedge i_clk_sys) begin
        if (tx_req === 1'b1) begin
            #1 tx_data = 8'($urandom);
            tx_valid = 1'b1;
            exp_tx.push_back(tx_data);
        end
    end

    task automatic check_val(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wbyte(input logic [7:0] d, input logic exp_ack);
        logic a;
        i_mst.wr_byte(d, a);
        check_val(9'(a), 9'(exp_ack));
    endtask

    // bounded wait for the stream, then in-order compare
    task automatic cmp_rx;
        repeat (400) if (got_rx.size() < exp_rx.size()) @(posedge i_clk_sys);
        check_val(9'(got_rx.size()), 9'(exp_rx.size()));
        foreach (exp_rx[i]) if (i < got_rx.size()) check_val(got_rx[i], exp_rx[i]);
        got_rx.delete();
        exp_rx.delete();
    endtask

    initial begin
        #600us;
        err_count++;
        report_and_stop();
    end

    initial begin
        logic [7:0] d;
        logic       a;
        int         n;
        void'($urandom(37321));
        repeat (10) @(posedge i_clk_sys);
        #1 i_rstn = 1'b1;
        repeat (20) @(posedge i_clk_sys); // short stand-in for warm-up
        // write: command then data, fast then slow bit rate
        for (int r = 0; r < 2; r++) begin
            i_mst.t_q = r ? 630 : 20;
            i_mst.start_cond();
            wbyte(ADDR_W, 1'b1);
            check_val(9'(active), 9'h001);
            for (int k = 0; k < 3; k++) begin
                d = (k == 2) ? 8'h80 : 8'($urandom);
                exp_rx.push_back({(k == 0), d});
                wbyte(d, 1'b1);
            end
            i_mst.stop_cond();
            cmp_rx();
        end
        i_mst.t_q = 20;
        // refusals: foreign address, busy, rejected command
        for (int c = 0; c < 3; c++) begin
            @(posedge i_clk_sys);
            #1 busy = (c == 1);
            accept = (c != 2);
            i_mst.start_cond();
            wbyte((c == 0) ? (ADDR_W ^ 8'h02) : ADDR_W, c == 2);
            check_val(9'(active), 9'(c == 2));
            wbyte(8'($urandom), 1'b0);
            i_mst.stop_cond();
        end
        check_val(9'(got_rx.size()), 9'h000);
        @(posedge i_clk_sys);
        #1 busy = 1'b0;
        accept = 1'b1;
        // command write, repeated start, then a read of random length
        i_mst.start_cond();
        wbyte(ADDR_W, 1'b1);
        d = 8'($urandom);
        exp_rx.push_back({1'b1, d});
        wbyte(d, 1'b1);
        rd_seen = 1'b0;
        exp_tx.delete();
        i_mst.start_cond();
        wbyte(ADDR_W | 8'h01, 1'b1);
        check_val(9'(rd_seen), 9'h001);
        n = 1 + $urandom % 4;
        for (int k = 0; k < n; k++) begin
            i_mst.rd_byte(k == n - 1, d);
            check_val(9'(d), 9'(exp_tx[k]));
        end
        #200 check_val(9'(sda_oe), 9'h000);
        i_mst.stop_cond();
        cmp_rx();
        // fill the buffer with the consumer stalled, then drain it
        stall = 1'b1;
        i_mst.start_cond();
        wbyte(ADDR_W, 1'b1);
        n = 0;
        a = 1'b1;
        while (a && n < 8) begin
            d = 8'($urandom);
            i_mst.wr_byte(d, a);
            if (a) exp_rx.push_back({(n == 0), d});
            if (a) n++;
        end
        i_mst.stop_cond();
        // fifo slots plus the output register hold the accepted bytes
        check_val(9'(n), 9'(`ISP_FIFO_DEPTH + 1));
        stall = 1'b0;
        cmp_rx();
        report_and_stop();
    end
endmodule

`default_nettype wire
